// File: core/sox_expander.sv
// serial-in parallel-out output expander with register access
//
// How it works
// RULE1: shift stages and storage, separate clocks, eight outputs
// RULE2: shift clock rise samples data, advances stages
// RULE3: first bit in ends at highest output
// RULE4: storage clock rise copies stages, stages unchanged; here via the fifo, held by the control hold bit, dropped if fifo full
// RULE5: serial in to first stage, last stage cascades
// RULE6: clear low zeroes stages asynchronously
// RULE7: enable low drives outputs, else released; the control force-off bit also releases them here
// RULE8: chain cascade output to next data input
// RULE9: controller link clock drives shift clock
// RULE10: controller select edge drives storage clock
// RULE11: controller link data drives serial input
// RULE12: controller port pin drives output enable
// RULE13: controller streams output data downstream
// RULE14: controller upstream receive channel unused
// RULE15: controller sends low bit first, remap
// RULE16: inverted controller clock gives mode 0
// RULE17: triggered mode sends one frame when idle
// RULE18: repetition mode sends frames continuously
// RULE19: eight shift clocks per expander per strobe
`timescale 1ns/1ns
`include "sox_consts.svh"
module sox_expander
    import sox_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // expander pins
    input wire logic shiftClockIn,
    input wire logic storageClockIn,
    input wire logic serialDataIn,
    input wire logic shiftClearN,
    input wire logic outputEnableN,
    output logic [7:0] parallelOut,
    output logic parallelOutOe,
    output logic cascadeSerialOut,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // axi4-lite read data
    input wire logic rvalid_unused_guard,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp
);
    // pin synchronisers and edge finders
    sox_pins_t pinRaw;
    sox_pins_t pinMeta_reg;
    sox_pins_t pinSync_reg;
    sox_pins_t pinPrev_reg;
    logic shiftEdge;
    logic storeEdge;

    // datapath state
    logic [7:0] stages_reg;
    logic [7:0] storage_reg;
    logic oeActive_reg;
    logic [7:0] bitCount_reg;
    logic [15:0] frames_reg;
    logic overflow_reg;
    logic shortFrame_reg;
    logic [1:0] ctrl_reg;

    // fifo wiring
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [7:0] fifoOutData;

    // bus state
    sox_wr_state_t wrState_reg;
    sox_rd_state_t rdState_reg;
    logic awHave_reg;
    logic [7:0] awAddr_reg;
    logic wHave_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic [1:0] bresp_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic doWrite;
    logic wrCtrl;
    logic wrEvent;
    sox_status_t status;

    function automatic logic isMapped(input logic [7:0] a);
        return (a == `SOX_OFF_CTRL) || (a == `SOX_OFF_STATUS) ||
               (a == `SOX_OFF_EVENT) || (a == `SOX_OFF_FRAMES);
    endfunction

    // ---- pins ----
    assign pinRaw = '{shiftClk: shiftClockIn, storeClk: storageClockIn,
                      serData: serialDataIn, outEnN: outputEnableN};

    always_ff @(posedge clk) begin
        if (srst) begin
            pinMeta_reg <= '{shiftClk: 1'b0, storeClk: 1'b0, serData: 1'b0, outEnN: 1'b1};
            pinSync_reg <= '{shiftClk: 1'b0, storeClk: 1'b0, serData: 1'b0, outEnN: 1'b1};
            pinPrev_reg <= '{shiftClk: 1'b0, storeClk: 1'b0, serData: 1'b0, outEnN: 1'b1};
        end else begin
            pinMeta_reg <= pinRaw;
            pinSync_reg <= pinMeta_reg;
            pinPrev_reg <= pinSync_reg;
        end
    end

    // rising edges of the two independent clocks
    assign shiftEdge = pinSync_reg.shiftClk && !pinPrev_reg.shiftClk; // RULE1 RULE2
    assign storeEdge = pinSync_reg.storeClk && !pinPrev_reg.storeClk; // RULE1 RULE4

    // ---- shift stages ----
    always_ff @(posedge clk or negedge shiftClearN) begin
        if (!shiftClearN) begin
            stages_reg <= `SOX_STAGES_RESET; // RULE6
        end else if (srst) begin
            stages_reg <= `SOX_STAGES_RESET;
        end else if (shiftEdge) begin
            stages_reg <= {stages_reg[6:0], pinSync_reg.serData}; // RULE2 RULE3 RULE5
        end
    end

    assign cascadeSerialOut = stages_reg[`SOX_STAGES-1]; // RULE5 RULE8

    // ---- bits shifted since last strobe ----
    always_ff @(posedge clk) begin
        if (srst) begin
            bitCount_reg <= 8'h00;
        end else if (storeEdge) begin
            bitCount_reg <= shiftEdge ? 8'h01 : 8'h00;
        end else if (shiftEdge && bitCount_reg != `SOX_BITCOUNT_MAX) begin
            bitCount_reg <= bitCount_reg + 8'h01;
        end
    end

    // strobe after a count that is zero or not whole bytes
    always_ff @(posedge clk) begin
        if (srst) begin
            shortFrame_reg <= 1'b0;
        end else if (storeEdge && (bitCount_reg == 8'h00 || bitCount_reg[2:0] != 3'h0)) begin
            shortFrame_reg <= 1'b1; // RULE19
        end else if (wrEvent && wData_reg[`SOX_EVT_SHORT_BIT]) begin
            shortFrame_reg <= 1'b0;
        end
    end

    // ---- storage path through the fifo ----
    sox_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .inValid(storeEdge),
        .inReady(fifoInReady),
        .inData(stages_reg), // RULE4
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    assign fifoOutReady = !ctrl_reg[`SOX_CTRL_HOLD_BIT];

    always_ff @(posedge clk) begin
        if (srst) begin
            storage_reg <= `SOX_STORE_RESET;
        end else if (fifoOutValid && fifoOutReady) begin
            storage_reg <= fifoOutData; // RULE1 RULE4
        end
    end

    // strobe refused while the fifo is full
    always_ff @(posedge clk) begin
        if (srst) begin
            overflow_reg <= 1'b0;
        end else if (storeEdge && !fifoInReady) begin
            overflow_reg <= 1'b1;
        end else if (wrEvent && wData_reg[`SOX_EVT_OVERFLOW_BIT]) begin
            overflow_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            frames_reg <= 16'h0000;
        end else if (storeEdge && fifoInReady) begin
            frames_reg <= frames_reg + 16'h0001;
        end
    end

    // ---- output drivers ----
    always_ff @(posedge clk) begin
        if (srst) begin
            oeActive_reg <= 1'b0;
        end else begin
            oeActive_reg <= !pinSync_reg.outEnN && !ctrl_reg[`SOX_CTRL_FORCE_OFF_BIT]; // RULE7 RULE12
        end
    end

    assign parallelOut = storage_reg; // RULE1
    assign parallelOutOe = oeActive_reg; // RULE7

    // ---- write channel ----
    assign awready = (wrState_reg == WR_IDLE) && !awHave_reg;
    assign wready = (wrState_reg == WR_IDLE) && !wHave_reg;
    assign doWrite = (wrState_reg == WR_IDLE) && awHave_reg && wHave_reg;
    assign wrCtrl = doWrite && (awAddr_reg == `SOX_OFF_CTRL) && wStrb_reg[0];
    assign wrEvent = doWrite && (awAddr_reg == `SOX_OFF_EVENT) && wStrb_reg[0];
    assign bvalid = (wrState_reg == WR_RESP);
    assign bresp = bresp_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            awHave_reg <= 1'b0;
            awAddr_reg <= 8'h00;
        end else if (awvalid && awready) begin
            awHave_reg <= 1'b1;
            awAddr_reg <= {awaddr[7:2], 2'b00};
        end else if (doWrite) begin
            awHave_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wHave_reg <= 1'b0;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
        end else if (wvalid && wready) begin
            wHave_reg <= 1'b1;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
        end else if (doWrite) begin
            wHave_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wrState_reg <= WR_IDLE;
            bresp_reg <= `SOX_RESP_OKAY;
        end else begin
            unique case (wrState_reg)
                WR_IDLE: begin
                    if (doWrite) begin
                        wrState_reg <= WR_RESP;
                        bresp_reg <= isMapped(awAddr_reg) ? `SOX_RESP_OKAY : `SOX_RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    if (bready) begin
                        wrState_reg <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_reg <= `SOX_CTRL_RESET;
        end else if (wrCtrl) begin
            ctrl_reg <= wData_reg[1:0];
        end
    end

    // ---- read channel ----
    assign status = '{bitCount: bitCount_reg, oeActive: oeActive_reg, overflow: overflow_reg,
                      full: !fifoInReady, empty: !fifoOutValid,
                      storage: storage_reg, stages: stages_reg};
    assign arready = (rdState_reg == RD_IDLE);
    assign rvalid = (rdState_reg == RD_RESP);
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    always_ff @(posedge clk) begin
        if (srst) begin
            rdState_reg <= RD_IDLE;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `SOX_RESP_OKAY;
        end else begin
            unique case (rdState_reg)
                RD_IDLE: begin
                    if (arvalid) begin
                        rdState_reg <= RD_RESP;
                        rresp_reg <= isMapped({araddr[7:2], 2'b00}) ? `SOX_RESP_OKAY : `SOX_RESP_SLVERR;
                        unique case ({araddr[7:2], 2'b00})
                            `SOX_OFF_CTRL: rdata_reg <= {30'h0000_0000, ctrl_reg};
                            `SOX_OFF_STATUS: rdata_reg <= {4'h0, status};
                            `SOX_OFF_EVENT: rdata_reg <= {30'h0000_0000, shortFrame_reg, overflow_reg};
                            `SOX_OFF_FRAMES: rdata_reg <= {16'h0000, frames_reg};
                            default: rdata_reg <= 32'h0000_0000;
                        endcase
                    end
                end
                RD_RESP: begin
                    if (rready) begin
                        rdState_reg <= RD_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// File: inc/sox_consts.svh
// offsets, field positions, reset values and fixed counts of the output expander
`ifndef SOX_CONSTS_SVH
`define SOX_CONSTS_SVH

// register byte offsets
`define SOX_OFF_CTRL 8'h00
`define SOX_OFF_STATUS 8'h04
`define SOX_OFF_EVENT 8'h08
`define SOX_OFF_FRAMES 8'h0c

// control fields
`define SOX_CTRL_HOLD_BIT 0
`define SOX_CTRL_FORCE_OFF_BIT 1
`define SOX_CTRL_RESET 2'h0

// event fields, write one to clear
`define SOX_EVT_OVERFLOW_BIT 0
`define SOX_EVT_SHORT_BIT 1

// reset values
`define SOX_STAGES_RESET 8'h00
`define SOX_STORE_RESET 8'h00

// bus answers
`define SOX_RESP_OKAY 2'h0
`define SOX_RESP_SLVERR 2'h2

// stages per expander and saturation of the bit counter
`define SOX_STAGES 8
`define SOX_BITCOUNT_MAX 8'hff

`endif

// File: inc/sox_pkg.sv
// types shared by the output expander files
package sox_pkg;

    typedef struct packed {
        logic shiftClk;
        logic storeClk;
        logic serData;
        logic outEnN;
    } sox_pins_t;

    typedef struct packed {
        logic [7:0] bitCount;
        logic oeActive;
        logic overflow;
        logic full;
        logic empty;
        logic [7:0] storage;
        logic [7:0] stages;
    } sox_status_t;

    typedef enum logic [0:0] {WR_IDLE, WR_RESP} sox_wr_state_t;
    typedef enum logic [0:0] {RD_IDLE, RD_RESP} sox_rd_state_t;

endpackage

// File: core/sox_fifo.sv
// fifo between the store strobe and the storage register
`timescale 1ns/1ns
module sox_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wrPtr_reg;
    logic [PW-1:0] rdPtr_reg;
    logic [PW:0] count_reg;
    logic push;
    logic pop;

    assign inReady = (count_reg != (PW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_reg <= '0;
        end else if (push) begin
            wrPtr_reg <= (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rdPtr_reg <= '0;
        end else if (pop) begin
            rdPtr_reg <= (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end
endmodule

// File: verification/sox_expander_asserts.sv
// port assertions of the output expander
`timescale 1ns/1ns
module sox_expander_asserts
    import sox_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pins
    input wire logic shiftClockIn,
    input wire logic shiftClearN,
    input wire logic outputEnableN,
    input wire logic parallelOutOe,
    input wire logic cascadeSerialOut,
    // bus handshakes
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence wrTaken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence rdTaken;
        arvalid && arready;
    endsequence
    sequence enableHigh;
        outputEnableN [*5];
    endsequence
    oe_release_a: assert property (enableHigh |-> !parallelOutOe)
        else $error("outputs driven while enable high");
    clear_zero_a: assert property (!shiftClearN |-> !cascadeSerialOut)
        else $error("cascade not cleared");
    shift_cause_a: assert property ($changed(cascadeSerialOut) && shiftClearN |->
        $past(shiftClockIn, 2) || $past(shiftClockIn, 3) || $past(shiftClockIn, 4))
        else $error("cascade moved without shift clock");
    write_answer_a: assert property (wrTaken |-> ##[1:3] bvalid)
        else $error("no write response");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped");
    read_answer_a: assert property (rdTaken |-> ##[1:2] rvalid)
        else $error("no read response");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data not held");
    write_busy_a: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while busy");
    read_busy_a: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
endmodule

bind sox_expander sox_expander_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.clk, .srst, .shiftClockIn, .shiftClearN,
    .outputEnableN, .parallelOutOe, .cascadeSerialOut, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
    .arvalid, .arready, .rvalid, .rready, .rdata);

// File: verification/sox_ctrl_model.sv
// behavioural serial controller driving the expander pins
`timescale 1ns/1ns
module sox_ctrl_model
    import sox_pkg::*;
(
    // clock
    input wire logic clk,
    // pins toward the expander
    output sox_pins_t pins
);
    initial pins = 4'h1;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one frame, msb first, one shift clock per bit
    task automatic sendBits(input logic [15:0] d, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            pins.serData <= d[i];
            tick(2);
            pins.shiftClk <= 1'b1;
            tick(4);
            pins.shiftClk <= 1'b0;
            tick(2);
        end
        pins.serData <= ~d[0];
        tick(1);
    endtask
    task automatic store();
        pins.storeClk <= 1'b1;
        tick(4);
        pins.storeClk <= 1'b0;
        tick(4);
    endtask
    task automatic enable(input logic on);
        pins.outEnN <= ~on;
        tick(1);
    endtask
endmodule

// File: verification/sox_expander_bench.sv
// self-checking bench of the output expander
`timescale 1ns/1ns
`include "sox_consts.svh"
module sox_expander_bench
    import sox_pkg::*;
;
    logic clk, srst, clearN, parallelOutOe, cascadeSerialOut;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, parallelOut;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [3:0] wstrb;
    logic [2:0] awprot, arprot;
    logic lateAck;
    sox_pins_t pins;
    int fails, cmp_count;
    sox_expander #(.FIFO_DEPTH(8)) dut (.clk, .srst, .shiftClockIn(pins.shiftClk), .storageClockIn(pins.storeClk),
        .serialDataIn(pins.serData), .shiftClearN(clearN), .outputEnableN(pins.outEnN), .parallelOut,
        .parallelOutOe, .cascadeSerialOut, .awvalid, .awready, .awaddr, .awprot, .wvalid, .wready, .wdata,
        .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot,
        .rvalid_unused_guard(1'b0), .rvalid, .rready, .rdata, .rresp);
    sox_ctrl_model model (.clk, .pins);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= !lateAck;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
        end
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= !lateAck;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic shiftStore;
        rd(`SOX_OFF_CTRL);
        chk(d, 32'h0);
        model.enable(1'b1);
        model.sendBits(16'hb4, 8);
        model.store();
        chk(32'(parallelOut), 32'hb4);
        chk(32'(parallelOutOe), 32'h1);
        rd(`SOX_OFF_STATUS);
        chk(d & 32'hffff, 32'hb4b4);
    endtask
    task automatic cascadeOut;
        model.sendBits(16'h3, 2);
        chk(32'(cascadeSerialOut), 32'h1);
        chk(32'(parallelOut), 32'hb4);
        rd(`SOX_OFF_STATUS);
        chk(d & 32'hff, 32'hd3);
    endtask
    task automatic clearStages;
        clearN <= 1'b0;
        repeat (2) @(posedge clk);
        chk(32'(cascadeSerialOut), 32'h0);
        rd(`SOX_OFF_STATUS);
        chk(d & 32'hffff, 32'hb400);
        clearN <= 1'b1;
    endtask
    task automatic enableOff;
        model.enable(1'b0);
        repeat (6) @(posedge clk);
        chk(32'(parallelOutOe), 32'h0);
        model.enable(1'b1);
        repeat (6) @(posedge clk);
        chk(32'(parallelOutOe), 32'h1);
    endtask
    task automatic fifoFill;
        wr(`SOX_OFF_CTRL, 32'h1);
        model.sendBits(16'h5a, 8);
        repeat (9) model.store();
        rd(`SOX_OFF_STATUS);
        chk(d & 32'h70000, 32'h60000);
        chk(32'(parallelOut), 32'hb4);
        wr(`SOX_OFF_CTRL, 32'h0);
        repeat (20) @(posedge clk);
        chk(32'(parallelOut), 32'h5a);
        rd(`SOX_OFF_EVENT);
        chk(d & 32'h3, 32'h3);
        wr(`SOX_OFF_EVENT, 32'h3);
        rd(`SOX_OFF_EVENT);
        chk(d & 32'h3, 32'h0);
        rd(`SOX_OFF_FRAMES);
        chk(d & 32'hffff, 32'h9);
    endtask
    task automatic badAddress;
        lateAck = 1'b1;
        rd(8'h10);
        chk(d, 32'h0);
        chk(32'(r), 32'(`SOX_RESP_SLVERR));
        wr(8'h10, 32'h1);
        chk(32'(r), 32'(`SOX_RESP_SLVERR));
        wstrb <= 4'h0;
        wr(`SOX_OFF_CTRL, 32'h2);
        chk(32'(r), 32'(`SOX_RESP_OKAY));
        wstrb <= 4'hf;
        rd(`SOX_OFF_CTRL);
        chk(d, 32'h0);
        lateAck = 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
    initial begin
        srst = 1'b1;
        clearN = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        awprot = 3'h0;
        arprot = 3'h0;
        lateAck = 1'b0;
        fails = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        shiftStore();
        cascadeOut();
        clearStages();
        enableOff();
        fifoFill();
        badAddress();
        tally_and_finish();
    end
endmodule
